// ---- pkg/imm_regs.svh ----
// Purpose: address map, field positions, reset values and timing counts
//          of the internal data memory and special function registers
// Assumes: included by the package and by the top module
// Notes:   definitions only
`ifndef IMM_REGS_SVH
`define IMM_REGS_SVH

// ----------------------------------------------------------------------
// special function register direct addresses
// ----------------------------------------------------------------------
`define IMM_SFR_P0          8'h80
`define IMM_SFR_SP          8'h81
`define IMM_SFR_DPL         8'h82
`define IMM_SFR_DPH         8'h83
`define IMM_SFR_P1          8'h90
`define IMM_SFR_P2          8'hA0
`define IMM_SFR_P3          8'hB0
`define IMM_SFR_PSW         8'hD0
`define IMM_SFR_ACC         8'hE0
`define IMM_SFR_B           8'hF0

// ----------------------------------------------------------------------
// reset values and read value of empty addresses
// ----------------------------------------------------------------------
`define IMM_RST_PORT        8'hFF
`define IMM_RST_SP          8'h07
`define IMM_RST_ZERO        8'h00
`define IMM_UNIMPL_RD       8'h00

// ----------------------------------------------------------------------
// layout of the internal ram
// ----------------------------------------------------------------------
`define IMM_BANK_BASE       3'h0
`define IMM_BIT_AREA        4'h2
`define IMM_SCRATCH_BASE    8'h30
`define IMM_PSW_RS_MSB      4
`define IMM_PSW_RS_LSB      3
`define IMM_CODE_ONCHIP_LIM 16'h2000

// ----------------------------------------------------------------------
// reset pin qualification
// ----------------------------------------------------------------------
`define IMM_MC_CLOCKS       12
`define IMM_RST_MC          2
`define IMM_RST_HOLD        (`IMM_MC_CLOCKS * `IMM_RST_MC)

`endif

// ---- pkg/imm_pkg.sv ----
// Purpose: types and address decoding shared by the memory map modules
// Assumes: imm_regs.svh on the include path
// Notes:   decode functions are used by the logic; assertions check their results against their own formulas
package imm_pkg;
`include "imm_regs.svh"

    // ------------------------------------------------------------------
    // access kinds issued by the core
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        IMM_OP_DIR  = 3'h0,
        IMM_OP_IND  = 3'h1,
        IMM_OP_BIT  = 3'h2,
        IMM_OP_REG  = 3'h3,
        IMM_OP_PUSH = 3'h4,
        IMM_OP_POP  = 3'h5
    } imm_op_t;

    typedef enum logic [0:0]
    {
        IMM_ST_IDLE = 1'b0,
        IMM_ST_WAIT = 1'b1
    } imm_state_t;

    // ram byte reached by an access
    function automatic logic [7:0] imm_ram_addr(input imm_op_t op, input logic [7:0] a,
                                                input logic [7:0] sp, input logic [1:0] bank);
        logic [7:0] r;
        r = a;
        case (op)
            IMM_OP_REG:  r = {`IMM_BANK_BASE, bank, a[2:0]};
            IMM_OP_BIT:  r = {`IMM_BIT_AREA, a[6:3]};
            IMM_OP_PUSH: r = 8'(sp + 8'h01);
            IMM_OP_POP:  r = sp;
            default:     r = a;
        endcase
        return r;
    endfunction : imm_ram_addr

    // direct byte and bit accesses above 7FH go to the register space
    function automatic logic imm_is_sfr(input imm_op_t op, input logic [7:0] a);
        return ((op == IMM_OP_DIR) || (op == IMM_OP_BIT)) && a[7];
    endfunction : imm_is_sfr

endpackage : imm_pkg

// ---- rtl/imm_ram.sv ----
// Purpose: 256 x 8 internal data ram, one write and one read port
// Assumes: read address sampled every edge
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/1ps
module imm_ram
    import imm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] raddr,
    output logic      [7:0] rdata_q
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] mem [0:255];   // whole ram, no reset on contents

    // write, then registered read of the old contents
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule : imm_ram

// ---- rtl/imm_rst_hold.sv ----
// Purpose: qualifies the reset pin before it resets the memory map
// Assumes: pin synchronous to sys_clk
// Notes:   pin must stay high for two machine cycles of twelve clocks
`timescale 1ns/1ps
`include "imm_regs.svh"
module imm_rst_hold
    import imm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic reset_pin,
    output logic      rst_req_q
);
    localparam int         HOLD_INT = `IMM_RST_HOLD;
    localparam logic [4:0] HOLD     = 5'(`IMM_RST_HOLD);

    typedef struct packed
    {
        logic [4:0] cnt;     // clocks the pin has been high
        logic       req;     // qualified reset request
    } imm_hold_t;

    imm_hold_t s_q;
    imm_hold_t s_d;

    // ------------------------------------------------------------------
    // count high samples, request once the hold time is met
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        if (reset_pin)
        begin
            s_d.cnt = (s_q.cnt == HOLD) ? s_q.cnt : 5'(s_q.cnt + 5'h01); // RULE_16
        end
        else
        begin
            s_d.cnt = 5'h00;
        end
        s_d.req = reset_pin && (s_d.cnt == HOLD); // RULE_16
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rst_req_q = s_q.req;

    AST_RST_QUAL: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_16
        $rose(rst_req_q) |-> ($past(s_q.cnt) == 5'(HOLD_INT - 1)) && $past(reset_pin))
        else $error("reset taken before pin was held long enough");
endmodule : imm_rst_hold

// ---- rtl/imm_data_map.sv ----
// Purpose: internal data memory and special function register map
// Assumes: core holds a request until acc_ready_q is high
// Notes:   one access in flight; answer one cycle after it is taken
`timescale 1ns/1ps
`include "imm_regs.svh"

// Overview of operation
// RULE_01: code and data spaces kept apart, 8K code on chip
// RULE_02: 256 bytes of ram beside the registers
// RULE_03: low 128 bytes reached directly and indirectly
// RULE_04: bytes 00H-1FH hold four register banks
// RULE_05: eight byte registers per bank
// RULE_06: bank zero selected after reset
// RULE_07: bytes 20H-2FH give bits 00H-7FH
// RULE_08: bytes 30H-7FH are plain scratch ram
// RULE_09: direct upper addresses reach function registers
// RULE_10: empty register addresses read junk, ignore writes
// RULE_11: software writes no ones to empty addresses
// RULE_12: stack pointer eight bits, reset to 07H
// RULE_13: stack pointer incremented before push writes
// RULE_14: data pointer sixteen bits or two bytes
// RULE_15: second register feeds multiply and divide
// RULE_16: reset pin held two machine cycles resets
// RULE_17: port registers are the port output latches
// RULE_18: indirect upper addresses reach upper ram
// RULE_19: status word field picks bank, offset eight
module imm_data_map
    import imm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        reset_pin,
    input  wire logic        acc_valid,
    input  wire imm_op_t     acc_op,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_addr,
    input  wire logic [7:0]  acc_wdata,
    input  wire logic        acc_bit,
    input  wire logic        data_pointer_load,
    input  wire logic [15:0] data_pointer_wdata,
    input  wire logic        data_pointer_inc,
    input  wire logic        md_write,
    input  wire logic [7:0]  md_b_data,
    input  wire logic [15:0] code_addr,
    output logic             acc_ready_q,
    output logic             rd_valid_q,
    output logic [7:0]       rd_data_q,
    output logic [7:0]       stack_pointer_q,
    output logic [15:0]      data_pointer_q,
    output logic [7:0]       accumulator_q,
    output logic [7:0]       b_register_q,
    output logic [1:0]       reg_bank_q,
    output logic [7:0]       port_zero_latch_q,
    output logic [7:0]       port_one_latch_q,
    output logic [7:0]       port_two_latch_q,
    output logic [7:0]       port_three_latch_q,
    output logic             code_internal_q
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        imm_state_t st;         // access sequencer
        logic       ready;      // free to take a request
        logic       done;       // answer strobe
        logic [7:0] rdata;      // answer data
        logic       wr;         // access writes
        logic       bitop;      // single bit access
        logic       special_function_register;        // access goes to register space
        logic       bitv;       // bit value to write
        logic [7:0] addr;       // address as issued
        logic [7:0] ram_a;      // ram byte of the access
        logic [7:0] wdata;      // byte to write
        logic [7:0] sp;         // stack_pointer
        logic [7:0] data_pointer_high;        // data_pointer_high
        logic [7:0] data_pointer_low;        // data_pointer_low
        logic [7:0] acc;        // accumulator
        logic [7:0] b;          // second arithmetic register
        logic [7:0] program_status_word;        // program_status_word, bit 0 unused
        logic [7:0] p0;         // port_zero_latch
        logic [7:0] p1;         // port_one_latch
        logic [7:0] p2;         // port_two_latch
        logic [7:0] p3;         // port_three_latch
        logic       code_int;   // code address lies on chip
    } imm_core_t;

    localparam imm_core_t RST_VAL = '{
        st: IMM_ST_IDLE, ready: 1'b1, done: 1'b0, rdata: `IMM_RST_ZERO,
        wr: 1'b0, bitop: 1'b0, special_function_register: 1'b0, bitv: 1'b0,
        addr: `IMM_RST_ZERO, ram_a: `IMM_RST_ZERO, wdata: `IMM_RST_ZERO,
        sp: `IMM_RST_SP, data_pointer_high: `IMM_RST_ZERO, data_pointer_low: `IMM_RST_ZERO,
        acc: `IMM_RST_ZERO, b: `IMM_RST_ZERO, program_status_word: `IMM_RST_ZERO,
        p0: `IMM_RST_PORT, p1: `IMM_RST_PORT, p2: `IMM_RST_PORT,
        p3: `IMM_RST_PORT, code_int: 1'b0};

    imm_core_t  s_q;         // registered state
    imm_core_t  s_d;         // next state
    logic       rst_req;     // qualified reset pin
    logic       ram_we;      // ram write strobe
    logic [7:0] ram_wd;      // ram write data
    logic [7:0] ram_ra;      // ram read address
    logic [7:0] ram_rd;      // ram read data, registered
    logic [7:0] sfr_byte;    // register byte of the access in flight
    logic [7:0] cur;         // byte read for the access in flight
    logic [7:0] newb;        // byte written back
    logic       take;        // request taken this edge

    // ------------------------------------------------------------------
    // register space read
    // ------------------------------------------------------------------
    function automatic logic [7:0] sfr_rd(input imm_core_t s, input logic [7:0] a);
        logic [7:0] r;
        r = `IMM_UNIMPL_RD; // RULE_10
        case (a)
            `IMM_SFR_P0:  r = s.p0;
            `IMM_SFR_SP:  r = s.sp;
            `IMM_SFR_DPL: r = s.data_pointer_low;
            `IMM_SFR_DPH: r = s.data_pointer_high;
            `IMM_SFR_P1:  r = s.p1;
            `IMM_SFR_P2:  r = s.p2;
            `IMM_SFR_P3:  r = s.p3;
            `IMM_SFR_PSW: r = {s.program_status_word[7:1], ^s.acc};
            `IMM_SFR_ACC: r = s.acc;
            `IMM_SFR_B:   r = s.b;
            default:      r = `IMM_UNIMPL_RD; // RULE_10
        endcase
        return r;
    endfunction : sfr_rd

    // ------------------------------------------------------------------
    // register space write, empty addresses change nothing
    // ------------------------------------------------------------------
    function automatic imm_core_t sfr_wr(input imm_core_t s, input logic [7:0] a,
                                         input logic [7:0] d);
        imm_core_t r;
        r = s;
        case (a)
            `IMM_SFR_P0:  r.p0 = d; // RULE_17
            `IMM_SFR_SP:  r.sp = d; // RULE_12
            `IMM_SFR_DPL: r.data_pointer_low = d; // RULE_14
            `IMM_SFR_DPH: r.data_pointer_high = d; // RULE_14
            `IMM_SFR_P1:  r.p1 = d; // RULE_17
            `IMM_SFR_P2:  r.p2 = d; // RULE_17
            `IMM_SFR_P3:  r.p3 = d; // RULE_17
            `IMM_SFR_PSW: r.program_status_word = {d[7:1], 1'b0};
            `IMM_SFR_ACC: r.acc = d;
            `IMM_SFR_B:   r.b = d; // RULE_15
            default:      r = s; // RULE_10 RULE_11
        endcase
        return r;
    endfunction : sfr_wr

    // ------------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------------
    imm_rst_hold u_rst_hold
    (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .reset_pin (reset_pin),
        .rst_req_q (rst_req)
    );

    imm_ram u_ram // RULE_02
    (
        .sys_clk (sys_clk),
        .we      (ram_we),
        .waddr   (s_q.ram_a),
        .wdata   (ram_wd),
        .raddr   (ram_ra),
        .rdata_q (ram_rd)
    );

    assign take = acc_valid && s_q.ready && (s_q.st == IMM_ST_IDLE);
    // bank field offsets working registers by eight per bank
    assign ram_ra = imm_ram_addr(acc_op, acc_addr, s_q.sp,
                                 s_q.program_status_word[`IMM_PSW_RS_MSB:`IMM_PSW_RS_LSB]); // RULE_04 RULE_05 RULE_19
    assign sfr_byte = s_q.bitop ? {s_q.addr[7:3], 3'h0} : s_q.addr;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d    = s_q;
        s_d.done = 1'b0;
        ram_we = 1'b0;
        ram_wd = `IMM_RST_ZERO;
        cur    = `IMM_RST_ZERO;
        newb   = `IMM_RST_ZERO;
        // only the low 8K of code space sits on chip
        s_d.code_int = (code_addr < `IMM_CODE_ONCHIP_LIM); // RULE_01
        unique case (s_q.st)
            IMM_ST_IDLE:
            begin
                // latch the request and its decoded targets
                if (take)
                begin
                    s_d.st    = IMM_ST_WAIT;
                    s_d.ready = 1'b0;
                    s_d.wr    = acc_write;
                    s_d.bitop = (acc_op == IMM_OP_BIT); // RULE_07
                    s_d.special_function_register   = imm_is_sfr(acc_op, acc_addr); // RULE_09 RULE_18
                    s_d.addr  = acc_addr;
                    s_d.ram_a = ram_ra; // RULE_03 RULE_08
                    s_d.wdata = acc_wdata;
                    s_d.bitv  = acc_bit;
                    if (acc_op == IMM_OP_PUSH)
                    begin
                        s_d.sp = 8'(s_q.sp + 8'h01); // RULE_13
                        s_d.wr = 1'b1;
                    end
                    else if (acc_op == IMM_OP_POP)
                    begin
                        s_d.sp = 8'(s_q.sp - 8'h01);
                        s_d.wr = 1'b0;
                    end
                end
            end
            IMM_ST_WAIT:
            begin
                // read the byte, answer, write back if asked
                cur = s_q.special_function_register ? sfr_rd(s_q, sfr_byte) : ram_rd;
                if (s_q.bitop)
                begin
                    s_d.rdata = {7'h00, cur[s_q.addr[2:0]]}; // RULE_07
                    newb = cur;
                    newb[s_q.addr[2:0]] = s_q.bitv;
                end
                else
                begin
                    s_d.rdata = cur;
                    newb = s_q.wdata;
                end
                if (s_q.wr && s_q.special_function_register)
                begin
                    s_d = sfr_wr(s_d, sfr_byte, newb); // RULE_09
                end
                else if (s_q.wr)
                begin
                    ram_we = 1'b1;
                    ram_wd = newb;
                end
                s_d.done  = 1'b1;
                s_d.ready = 1'b1;
                s_d.st    = IMM_ST_IDLE;
            end
        endcase
        // whole sixteen bit data pointer port wins over byte writes
        if (data_pointer_load)
        begin
            {s_d.data_pointer_high, s_d.data_pointer_low} = data_pointer_wdata; // RULE_14
        end
        else if (data_pointer_inc)
        begin
            {s_d.data_pointer_high, s_d.data_pointer_low} = 16'({s_q.data_pointer_high, s_q.data_pointer_low} + 16'h0001); // RULE_14
        end
        // multiply and divide result into the second register
        if (md_write)
        begin
            s_d.b = md_b_data; // RULE_15
        end
        // qualified reset pin returns the whole state register to reset values; ram contents are kept
        if (rst_req)
        begin
            s_d = RST_VAL; // RULE_06 RULE_12 RULE_16
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= RST_VAL; // RULE_06 RULE_12
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from the state register
    // ------------------------------------------------------------------
    assign acc_ready_q        = s_q.ready;
    assign rd_valid_q         = s_q.done;
    assign rd_data_q          = s_q.rdata;
    assign stack_pointer_q    = s_q.sp;
    assign data_pointer_q     = {s_q.data_pointer_high, s_q.data_pointer_low};
    assign accumulator_q      = s_q.acc;
    assign b_register_q       = s_q.b;
    assign reg_bank_q         = s_q.program_status_word[`IMM_PSW_RS_MSB:`IMM_PSW_RS_LSB];
    assign port_zero_latch_q  = s_q.p0;
    assign port_one_latch_q   = s_q.p1;
    assign port_two_latch_q   = s_q.p2;
    assign port_three_latch_q = s_q.p3;
    assign code_internal_q    = s_q.code_int;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_RESET_VALUES: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_12
        rst_req |=> (s_q.sp == 8'h07) && (reg_bank_q == 2'h0) && (s_q.p0 == 8'hFF))
        else $error("reset values wrong after reset request");
    AST_PUSH_PRE_INC: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_13
        (take && acc_op == IMM_OP_PUSH && !rst_req && !md_write)
        |=> ram_we && (s_q.ram_a == s_q.sp) && (s_q.sp == 8'($past(s_q.sp) + 8'h01)))
        else $error("push did not increment before writing");
    AST_BANK_OFFSET: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_19
        (take && acc_op == IMM_OP_REG)
        |-> ram_ra == 8'({s_q.program_status_word[4:3], 3'h0} + {5'h00, acc_addr[2:0]}))
        else $error("working register not offset by bank");
    AST_BIT_MAP: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_07
        (take && acc_op == IMM_OP_BIT && !acc_addr[7])
        |-> ram_ra == 8'(8'h20 + {5'h00, acc_addr[6:3]}))
        else $error("bit address maps to wrong byte");
    AST_IND_UPPER: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_18
        (take && acc_op == IMM_OP_IND) |=> !s_q.special_function_register && (s_q.ram_a == $past(acc_addr)))
        else $error("indirect access left the ram");
    AST_DIR_UPPER: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_09
        (take && acc_op == IMM_OP_DIR) |=> (s_q.special_function_register == $past(acc_addr[7])))
        else $error("direct access decoded to wrong space");
    AST_EMPTY_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_10
        (s_q.st == IMM_ST_WAIT && s_q.wr && s_q.special_function_register && !s_q.bitop
         && s_q.addr == 8'h85 && !rst_req && !data_pointer_load && !data_pointer_inc && !md_write)
        |=> $stable({s_q.sp, s_q.data_pointer_high, s_q.data_pointer_low, s_q.acc, s_q.b, s_q.program_status_word, s_q.p0, s_q.p1}))
        else $error("write to empty address changed a register");
    AST_DATA_POINTER_WORD: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_14
        (data_pointer_load && !rst_req) |=> data_pointer_q == $past(data_pointer_wdata))
        else $error("data pointer word load lost");
    AST_MD_OPERAND: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_15
        (md_write && !rst_req) |=> b_register_q == $past(md_b_data))
        else $error("multiply divide result missing in second register");
    AST_ANSWER_TIME: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_03
        (take && !rst_req) |=> !acc_ready_q ##1 (rd_valid_q && acc_ready_q))
        else $error("answer not given one cycle after take");
    AST_CODE_SPACE: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_01
        !rst_req |=> code_internal_q == ($past(code_addr[15:13]) == 3'h0))
        else $error("on chip code window wrong");
endmodule : imm_data_map

// ---- tb/imm_core_model.sv ----
// Purpose: core side, issues map accesses
// Assumes: request held until taken
// Notes:   released lines show inverted data
`timescale 1ns/1ps
module imm_core_model
    import imm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       acc_ready_q,
    input  wire logic       rd_valid_q,
    input  wire logic [7:0] rd_data_q,
    output logic            acc_valid,
    output imm_op_t         acc_op,
    output logic            acc_write,
    output logic      [7:0] acc_addr,
    output logic      [7:0] acc_wdata,
    output logic            acc_bit
);
    initial {acc_valid, acc_op, acc_write, acc_addr, acc_wdata, acc_bit} = '0;
    // one access: hold until taken, answer two edges on
    task automatic xfer(input imm_op_t o, input logic w, input logic [7:0] a, d,
                        output logic [7:0] rd);
        @(negedge sys_clk);
        {acc_valid, acc_op, acc_write, acc_addr, acc_wdata, acc_bit} = {1'b1, o, w, a, d, d[0]};
        @(posedge sys_clk);
        while (acc_ready_q !== 1'b1)
            @(posedge sys_clk);
        @(negedge sys_clk);
        {acc_valid, acc_addr, acc_wdata} = {1'b0, ~a, ~d};
        @(negedge sys_clk);
        rd = (rd_valid_q === 1'b1) ? rd_data_q : 8'hXX;
    endtask : xfer
endmodule : imm_core_model

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the data map
// Assumes: inputs change at falling edge
// Notes:   reset pin pulses short and long
`timescale 1ns/1ps
module tb_top
    import imm_pkg::*;
;
    logic sys_clk = 0, rstn = 0, reset_pin = 0, data_pointer_load = 0, data_pointer_inc = 0, md_write = 0;
    logic [15:0] data_pointer_wdata = 0, code_addr = 0, data_pointer_q;
    logic [7:0]  md_b_data = 0, r, rd_data_q, stack_pointer_q, accumulator_q, b_register_q;
    logic [7:0]  port_zero_latch_q, port_one_latch_q, port_two_latch_q, port_three_latch_q;
    logic [7:0]  acc_addr, acc_wdata;
    logic [1:0]  reg_bank_q;
    logic        acc_valid, acc_write, acc_bit, acc_ready_q, rd_valid_q, code_internal_q;
    imm_op_t     acc_op;
    int          bad_count = 0, checks = 0;
    always #4 sys_clk = ~sys_clk;
    imm_data_map u_imm_data_map (.sys_clk, .rstn, .reset_pin, .acc_valid, .acc_op,
        .acc_write, .acc_addr, .acc_wdata, .acc_bit, .data_pointer_load, .data_pointer_wdata, .data_pointer_inc,
        .md_write, .md_b_data, .code_addr, .acc_ready_q, .rd_valid_q, .rd_data_q,
        .stack_pointer_q, .data_pointer_q, .accumulator_q, .b_register_q, .reg_bank_q,
        .port_zero_latch_q, .port_one_latch_q, .port_two_latch_q, .port_three_latch_q,
        .code_internal_q);
    imm_core_model u_imm_core_model (.sys_clk, .acc_ready_q, .rd_valid_q, .rd_data_q,
        .acc_valid, .acc_op, .acc_write, .acc_addr, .acc_wdata, .acc_bit);
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic ax(input imm_op_t o, input logic w, input logic [7:0] a, d);
        u_imm_core_model.xfer(o, w, a, d, r);
    endtask : ax
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // reset values, banks, bits, upper ram
    task automatic t_map;
        chk("sp", 8'h07, stack_pointer_q);
        chk("bank", 2'h0, reg_bank_q);
        chk("p3", 8'hFF, port_three_latch_q);
        chk("p0", 8'hFF, port_zero_latch_q);
        chk("p2", 8'hFF, port_two_latch_q);
        chk("dp0", 16'h0000, data_pointer_q);
        code_addr = 16'h2000;
        @(negedge sys_clk);
        chk("code out", 1'b0, code_internal_q);
        code_addr = 16'h1FFF;
        @(negedge sys_clk);
        chk("code", 1'b1, code_internal_q);
        ax(IMM_OP_DIR, 1, 8'hD0, 8'h18);
        chk("bank3", 2'h3, reg_bank_q);
        ax(IMM_OP_REG, 1, 8'h02, 8'hA5);
        ax(IMM_OP_DIR, 0, 8'h1A, 8'h00);
        chk("r2", 8'hA5, r);
        ax(IMM_OP_DIR, 1, 8'h21, 8'h00);
        ax(IMM_OP_BIT, 1, 8'h0A, 8'h01);
        ax(IMM_OP_DIR, 0, 8'h21, 8'h00);
        chk("bitbyte", 8'h04, r);
        ax(IMM_OP_IND, 1, 8'h90, 8'h3C);
        chk("p1", 8'hFF, port_one_latch_q);
        ax(IMM_OP_IND, 0, 8'h90, 8'h00);
        chk("up", 8'h3C, r);
        ax(IMM_OP_DIR, 1, 8'h90, 8'h5A);
        chk("p1w", 8'h5A, port_one_latch_q);
        ax(IMM_OP_DIR, 1, 8'hE0, 8'hC3);
        chk("acc", 8'hC3, accumulator_q);
        ax(IMM_OP_DIR, 1, 8'h40, 8'h66);
        ax(IMM_OP_IND, 0, 8'h40, 8'h00);
        chk("low", 8'h66, r);
        $display("t_map done");
    endtask : t_map
    // stack, empty address, data pointer, second register
    task automatic t_regs;
        ax(IMM_OP_DIR, 1, 8'hD0, 8'h00);
        ax(IMM_OP_PUSH, 0, 8'h00, 8'h55);
        chk("push sp", 8'h08, stack_pointer_q);
        ax(IMM_OP_DIR, 0, 8'h08, 8'h00);
        chk("stk", 8'h55, r);
        ax(IMM_OP_POP, 0, 8'h00, 8'h00);
        chk("pop", 8'h55, r);
        ax(IMM_OP_DIR, 1, 8'h85, 8'h00);
        ax(IMM_OP_DIR, 0, 8'h85, 8'h00);
        chk("empty", 8'h00, r);
        chk("empty sp", 8'h07, stack_pointer_q);
        {data_pointer_wdata, data_pointer_load} = {16'h1234, 1'b1};
        @(negedge sys_clk);
        {data_pointer_load, data_pointer_inc} = 2'b01;
        @(negedge sys_clk);
        data_pointer_inc = 0;
        chk("dp", 16'h1235, data_pointer_q);
        ax(IMM_OP_DIR, 1, 8'h82, 8'h77);
        chk("dpl", 16'h1277, data_pointer_q);
        {md_b_data, md_write} = {8'h9C, 1'b1};
        @(negedge sys_clk);
        md_write = 0;
        chk("b out", 8'h9C, b_register_q);
        ax(IMM_OP_DIR, 0, 8'hF0, 8'h00);
        chk("b", 8'h9C, r);
        $display("t_regs done");
    endtask : t_regs
    // reset pin: short pulse ignored, long one resets
    task automatic t_pin;
        ax(IMM_OP_PUSH, 0, 8'h00, 8'h11);
        reset_pin = 1;
        repeat (10) @(negedge sys_clk);
        reset_pin = 0;
        @(negedge sys_clk);
        chk("short", 8'h08, stack_pointer_q);
        reset_pin = 1;
        repeat (24) @(negedge sys_clk);
        chk("early", 8'h08, stack_pointer_q);
        repeat (2) @(negedge sys_clk);
        chk("long", 8'h07, stack_pointer_q);
        chk("p1r", 8'hFF, port_one_latch_q);
        reset_pin = 0;
        $display("t_pin done");
    endtask : t_pin
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rstn = 1;
        t_map;
        t_regs;
        t_pin;
        print_verdict;
    end
    initial
    begin
        #20us;
        bad_count++;
        print_verdict;
    end
endmodule : tb_top
